// >>> logic/tmr16_pkg.sv
// package of constants and types for the 16-bit timer/counter core
`default_nettype none
package tmr16_pkg;
   // byte locations on the 8-bit processor bus
   localparam logic [3:0] ADDR_COUNT_LO = 4'h0;
   localparam logic [3:0] ADDR_COUNT_HI = 4'h1;
   localparam logic [3:0] ADDR_CMP_A_LO = 4'h2;
   localparam logic [3:0] ADDR_CMP_A_HI = 4'h3;
   localparam logic [3:0] ADDR_CMP_B_LO = 4'h4;
   localparam logic [3:0] ADDR_CMP_B_HI = 4'h5;
   localparam logic [3:0] ADDR_CAPT_LO = 4'h6;
   localparam logic [3:0] ADDR_CAPT_HI = 4'h7;
   localparam logic [3:0] ADDR_CTRL_A = 4'h8;
   localparam logic [3:0] ADDR_CTRL_B = 4'h9;
   // field positions in the control registers
   localparam int CTRL_A_WGM_LSB = 0;  // waveform mode bits 1:0 in control a
   localparam int CTRL_B_WGM_LSB = 3;  // waveform mode bits 3:2 at bits 4:3 in control b
   localparam int CTRL_B_CS_LSB = 0;   // tick source select bits 2:0 in control b
   // reset values
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] REG16_RESET = 16'h0000;
   // counter landmarks
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   // tick source select codes
   localparam logic [2:0] CS_STOPPED = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   // prescaler taps
   localparam int PRESCALE_WIDTH = 10;
   // top source for a waveform mode
   typedef enum logic [2:0] {
      TMR16_TOP_MAX, TMR16_TOP_8, TMR16_TOP_9, TMR16_TOP_10, TMR16_TOP_CMPA, TMR16_TOP_CAPT
   } tmr16_top_type;
endpackage : tmr16_pkg
`default_nettype wire

// >>> logic/tmr16_tick_if.sv
// interface carrying the tick request between prescaler and counter core
`timescale 1ns/10ps
`default_nettype none
interface tmr16_tick_if;
   logic [2:0] select; // tick source select
   logic ext_pin;      // synchronised external pin level
   logic tick;         // one-cycle timer tick
   modport core (output select, output ext_pin, input tick);
   modport gen (input select, input ext_pin, output tick);
endinterface : tmr16_tick_if
`default_nettype wire

// >>> logic/tmr16_tick_gen.sv
// tick generator: prescaler taps and external edge detect
`timescale 1ns/10ps
`default_nettype none
module tmr16_tick_gen (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   tmr16_tick_if.gen tick_bus
);
   logic [tmr16_pkg::PRESCALE_WIDTH-1:0] pre_reg; // free-running prescaler
   logic [tmr16_pkg::PRESCALE_WIDTH-1:0] pre_next;
   logic ext_prev_reg; // previous external level
   logic ext_prev_next;
   logic tick_c;       // combinational tick

   // next values for prescaler and edge detector
   always_comb begin
      pre_next = pre_reg + 1'b1;
      ext_prev_next = tick_bus.ext_pin;
   end

   // register the prescaler state
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pre_reg <= '0;
         ext_prev_reg <= 1'b0;
      end else begin
         pre_reg <= pre_next;
         ext_prev_reg <= ext_prev_next;
      end
   end

   // select the tick source; stopped gives no tick
   always_comb begin
      case (tick_bus.select)
         tmr16_pkg::CS_STOPPED: tick_c = 1'b0;
         tmr16_pkg::CS_DIV1: tick_c = 1'b1;
         tmr16_pkg::CS_DIV8: tick_c = (pre_reg[2:0] == 3'h7);
         tmr16_pkg::CS_DIV64: tick_c = (pre_reg[5:0] == 6'h3f);
         tmr16_pkg::CS_DIV256: tick_c = (pre_reg[7:0] == 8'hff);
         tmr16_pkg::CS_DIV1024: tick_c = (pre_reg == 10'h3ff);
         tmr16_pkg::CS_EXT_FALL: tick_c = ext_prev_reg & ~tick_bus.ext_pin;
         tmr16_pkg::CS_EXT_RISE: tick_c = ~ext_prev_reg & tick_bus.ext_pin;
         default: tick_c = 1'b0;
      endcase
   end
   assign tick_bus.tick = tick_c;
endmodule : tmr16_tick_gen
`default_nettype wire

// >>> logic/tmr16_core.sv
// 16-bit timer/counter core with shared high-byte latch on an 8-bit bus
`timescale 1ns/10ps
`default_nettype none
module tmr16_core (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [3:0] i_addr,       // byte location
   input wire logic i_wr,               // one-cycle write strobe
   input wire logic i_rd,               // one-cycle read strobe
   input wire logic [7:0] i_wdata,      // write data
   output logic [7:0] o_rdata,          // read data, valid cycle after i_rd
   input wire logic i_ext_pin,          // external tick pin, asynchronous
   input wire logic i_capture,          // capture strobe from same-clock logic
   input wire logic i_overflow_clear,   // clear overflow flag (interrupt taken or write one)
   output logic o_overflow_flag,        // sticky overflow flag, interrupt request
   output logic o_bottom,               // count equals zero
   output logic o_top,                  // count equals top
   output logic o_max,                  // count equals all ones
   output logic [15:0] o_count_value    // current count
);
   logic [15:0] count_reg, count_next;    // counter
   logic [7:0] latch_reg, latch_next;     // shared high-byte latch
   logic [15:0] cmpa_buf_reg, cmpa_buf_next; // compare a buffer
   logic [15:0] cmpa_reg, cmpa_next;      // compare a active value
   logic [15:0] cmpb_buf_reg, cmpb_buf_next;
   logic [15:0] cmpb_reg, cmpb_next;
   logic [15:0] capt_reg, capt_next;      // capture register
   logic [7:0] ctrl_a_reg, ctrl_a_next;   // timer_control_a
   logic [7:0] ctrl_b_reg, ctrl_b_next;   // timer_control_b
   logic dir_down_reg, dir_down_next;     // count direction, high when down
   logic ovf_reg, ovf_next;               // overflow_flag
   logic [7:0] rdata_reg, rdata_next;     // registered read data
   logic ext_sync1_reg, ext_sync2_reg;    // external pin synchroniser
   logic [3:0] waveform_mode_field;       // four-bit mode
   tmr16_pkg::tmr16_top_type top_src;     // selected top source
   logic [15:0] top_value;                // resolved top
   logic pwm_mode;                        // double buffering active
   logic dual_slope;                      // phase correct counting
   logic count_zero, count_top, count_max;
   logic rd_lo;                           // low-byte read strobe

   tmr16_tick_if tick_bus ();             // tick request to prescaler

   // tick generator instance
   tmr16_tick_gen u_tick_gen (
      .i_clk_sys(i_clk_sys),
      .i_reset_n(i_reset_n),
      .tick_bus(tick_bus.gen)
   );

   // join a high byte and low byte
   function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
      join16 = {hi, lo};
   endfunction : join16

   // the pin comes from outside the clock domain; only the second
   // stage feeds the edge detector in the tick generator
   // two-flop synchroniser for the external pin
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ext_sync1_reg <= 1'b0;
         ext_sync2_reg <= 1'b0;
      end else begin
         ext_sync1_reg <= i_ext_pin;
         ext_sync2_reg <= ext_sync1_reg;
      end
   end

   assign tick_bus.ext_pin = ext_sync2_reg;
   assign tick_bus.select = ctrl_b_reg[tmr16_pkg::CTRL_B_CS_LSB +: 3];

   // mode field split over both control registers
   assign waveform_mode_field = {ctrl_b_reg[tmr16_pkg::CTRL_B_WGM_LSB +: 2],
                                 ctrl_a_reg[tmr16_pkg::CTRL_A_WGM_LSB +: 2]};

   // pwm_mode marks the modes whose compare registers are double
   // buffered; normal and clear-on-top modes write them directly
   // decode top source and counting style from the mode
   always_comb begin
      top_src = tmr16_pkg::TMR16_TOP_MAX;
      dual_slope = 1'b0;
      pwm_mode = 1'b1;
      case (waveform_mode_field)
         4'h0: pwm_mode = 1'b0;                                   // normal
         4'h1: begin top_src = tmr16_pkg::TMR16_TOP_8; dual_slope = 1'b1; end
         4'h2: begin top_src = tmr16_pkg::TMR16_TOP_9; dual_slope = 1'b1; end
         4'h3: begin top_src = tmr16_pkg::TMR16_TOP_10; dual_slope = 1'b1; end
         4'h4: begin top_src = tmr16_pkg::TMR16_TOP_CMPA; pwm_mode = 1'b0; end // ctc
         4'h5: top_src = tmr16_pkg::TMR16_TOP_8;
         4'h6: top_src = tmr16_pkg::TMR16_TOP_9;
         4'h7: top_src = tmr16_pkg::TMR16_TOP_10;
         4'h8, 4'ha: begin top_src = tmr16_pkg::TMR16_TOP_CAPT; dual_slope = 1'b1; end
         4'h9, 4'hb: begin top_src = tmr16_pkg::TMR16_TOP_CMPA; dual_slope = 1'b1; end
         4'hc: begin top_src = tmr16_pkg::TMR16_TOP_CAPT; pwm_mode = 1'b0; end // ctc
         4'he: top_src = tmr16_pkg::TMR16_TOP_CAPT;
         4'hf: top_src = tmr16_pkg::TMR16_TOP_CMPA;
         default: pwm_mode = 1'b0;                                // reserved acts as normal
      endcase
   end

   // resolve the top value
   always_comb begin
      case (top_src)
         tmr16_pkg::TMR16_TOP_8: top_value = tmr16_pkg::TOP_8BIT;
         tmr16_pkg::TMR16_TOP_9: top_value = tmr16_pkg::TOP_9BIT;
         tmr16_pkg::TMR16_TOP_10: top_value = tmr16_pkg::TOP_10BIT;
         tmr16_pkg::TMR16_TOP_CMPA: top_value = cmpa_reg;
         tmr16_pkg::TMR16_TOP_CAPT: top_value = capt_reg;
         default: top_value = tmr16_pkg::COUNT_MAX;
      endcase
   end

   // a read strobe on the count or capture low location also
   // refreshes the latch; control bytes are plain 8-bit registers
   // landmark compares
   assign count_zero = (count_reg == tmr16_pkg::COUNT_BOTTOM);
   assign count_max = (count_reg == tmr16_pkg::COUNT_MAX);
   assign count_top = (count_reg == top_value);
   assign rd_lo = i_rd & ~i_addr[0] & (i_addr < tmr16_pkg::ADDR_CTRL_A);

   // priority inside this process, lowest first: tick, capture,
   // processor write; a later assignment wins, so a write to the
   // counter overrides the count the tick scheduled for that edge
   // next state of counter, latch, registers and flag
   always_comb begin
      count_next = count_reg;
      dir_down_next = dir_down_reg;
      latch_next = latch_reg;
      cmpa_buf_next = cmpa_buf_reg;
      cmpa_next = cmpa_reg;
      cmpb_buf_next = cmpb_buf_reg;
      cmpb_next = cmpb_reg;
      capt_next = capt_reg;
      ctrl_a_next = ctrl_a_reg;
      ctrl_b_next = ctrl_b_reg;
      ovf_next = ovf_reg & ~i_overflow_clear;
      // counting on each tick
      if (tick_bus.tick) begin
         // dual slope: up to top, down to zero, flag at the turnaround at zero
         if (dual_slope) begin
            if (!dir_down_reg && count_top) begin
               dir_down_next = 1'b1;
               count_next = count_reg - 16'h0001;
            end else if (dir_down_reg && count_zero) begin
               dir_down_next = 1'b0;
               count_next = count_reg + 16'h0001;
               ovf_next = 1'b1;
            end else if (dir_down_reg) begin
               count_next = count_reg - 16'h0001;
            end else begin
               count_next = count_reg + 16'h0001;
            end
         end else begin
            // single slope: wrap at top or at all ones
            dir_down_next = 1'b0;
            if (top_src != tmr16_pkg::TMR16_TOP_MAX && count_top) begin
               count_next = tmr16_pkg::COUNT_BOTTOM;
               if (pwm_mode) begin
                  ovf_next = 1'b1;
               end
            end else begin
               count_next = count_reg + 16'h0001;
               if (count_max) begin
                  ovf_next = 1'b1;
               end
            end
         end
         // buffered compares load from their buffers at top
         if (pwm_mode && ((dual_slope && count_top && !dir_down_reg) || (!dual_slope && count_top))) begin
            cmpa_next = cmpa_buf_reg;
            cmpb_next = cmpb_buf_reg;
         end
      end
      // capture event, only when capture is not top
      if (i_capture && top_src != tmr16_pkg::TMR16_TOP_CAPT) begin
         capt_next = count_reg;
      end
      // high locations only fill the shared latch; a low write joins
      // the latch with the new byte, so one edge loads all 16 bits; a capture low write lands only when capture is top
      // processor writes
      if (i_wr) begin
         case (i_addr)
            tmr16_pkg::ADDR_COUNT_LO: count_next = join16(latch_reg, i_wdata);
            tmr16_pkg::ADDR_CMP_A_LO: begin
               cmpa_buf_next = join16(latch_reg, i_wdata);
               if (!pwm_mode) begin
                  cmpa_next = join16(latch_reg, i_wdata);
               end
            end
            tmr16_pkg::ADDR_CMP_B_LO: begin
               cmpb_buf_next = join16(latch_reg, i_wdata);
               if (!pwm_mode) begin
                  cmpb_next = join16(latch_reg, i_wdata);
               end
            end
            tmr16_pkg::ADDR_CAPT_LO: begin
               if (top_src == tmr16_pkg::TMR16_TOP_CAPT) begin
                  capt_next = join16(latch_reg, i_wdata);
               end
            end
            tmr16_pkg::ADDR_COUNT_HI, tmr16_pkg::ADDR_CMP_A_HI,
            tmr16_pkg::ADDR_CMP_B_HI, tmr16_pkg::ADDR_CAPT_HI: latch_next = i_wdata;
            tmr16_pkg::ADDR_CTRL_A: ctrl_a_next = i_wdata;
            tmr16_pkg::ADDR_CTRL_B: ctrl_b_next = i_wdata;
            default: ; // unmapped write ignored
         endcase
      end
      // count and capture low-byte reads copy high byte into latch
      if (rd_lo) begin
         case (i_addr)
            tmr16_pkg::ADDR_COUNT_LO: latch_next = count_reg[15:8];
            tmr16_pkg::ADDR_CAPT_LO: latch_next = capt_reg[15:8];
            default: ; // compare reads leave the latch alone
         endcase
      end
   end

   // read data is registered: it shows up one edge after the strobe
   // and stays until the next read, so the processor may sample late
   // read data mux
   always_comb begin
      rdata_next = rdata_reg;
      if (i_rd) begin
         case (i_addr)
            tmr16_pkg::ADDR_COUNT_LO: rdata_next = count_reg[7:0];
            tmr16_pkg::ADDR_CMP_A_LO: rdata_next = cmpa_buf_reg[7:0];
            tmr16_pkg::ADDR_CMP_A_HI: rdata_next = cmpa_buf_reg[15:8];
            tmr16_pkg::ADDR_CMP_B_LO: rdata_next = cmpb_buf_reg[7:0];
            tmr16_pkg::ADDR_CMP_B_HI: rdata_next = cmpb_buf_reg[15:8];
            tmr16_pkg::ADDR_CAPT_LO: rdata_next = capt_reg[7:0];
            tmr16_pkg::ADDR_COUNT_HI, tmr16_pkg::ADDR_CAPT_HI: rdata_next = latch_reg;
            tmr16_pkg::ADDR_CTRL_A: rdata_next = ctrl_a_reg;
            tmr16_pkg::ADDR_CTRL_B: rdata_next = ctrl_b_reg;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // reset clears every register, so the timer comes up stopped
   // with an empty latch and the overflow flag low
   // register all state
   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_reg <= tmr16_pkg::COUNT_RESET;
         latch_reg <= tmr16_pkg::LATCH_RESET;
         cmpa_buf_reg <= tmr16_pkg::REG16_RESET;
         cmpa_reg <= tmr16_pkg::REG16_RESET;
         cmpb_buf_reg <= tmr16_pkg::REG16_RESET;
         cmpb_reg <= tmr16_pkg::REG16_RESET;
         capt_reg <= tmr16_pkg::REG16_RESET;
         ctrl_a_reg <= tmr16_pkg::CTRL_RESET;
         ctrl_b_reg <= tmr16_pkg::CTRL_RESET;
         dir_down_reg <= 1'b0;
         ovf_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         count_reg <= count_next;
         latch_reg <= latch_next;
         cmpa_buf_reg <= cmpa_buf_next;
         cmpa_reg <= cmpa_next;
         cmpb_buf_reg <= cmpb_buf_next;
         cmpb_reg <= cmpb_next;
         capt_reg <= capt_next;
         ctrl_a_reg <= ctrl_a_next;
         ctrl_b_reg <= ctrl_b_next;
         dir_down_reg <= dir_down_next;
         ovf_reg <= ovf_next;
         rdata_reg <= rdata_next;
      end
   end

   // landmarks are combinational from the count register and so
   // follow it in the same cycle
   // outputs
   assign o_rdata = rdata_reg;
   assign o_overflow_flag = ovf_reg;
   assign o_bottom = count_zero;
   assign o_top = count_top;
   assign o_max = count_max;
   assign o_count_value = count_reg;
endmodule : tmr16_core
`default_nettype wire

// >>> verif/tmr16_core_props.sv
// checker of the timer core port behaviour
`timescale 1ns/10ps
`default_nettype none
module tmr16_core_chk (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic i_overflow_clear,
   input wire logic o_overflow_flag,
   input wire logic o_bottom,
   input wire logic o_top,
   input wire logic o_max,
   input wire logic [15:0] o_count_value
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // strobes on the two counter byte locations
   wire logic wr_lo = i_wr && i_addr == tmr16_pkg::ADDR_COUNT_LO;
   wire logic wr_hi = i_wr && i_addr == tmr16_pkg::ADDR_COUNT_HI;
   wire logic rd_lo = i_rd && i_addr == tmr16_pkg::ADDR_COUNT_LO;
   wire logic rd_hi = i_rd && i_addr == tmr16_pkg::ADDR_COUNT_HI;
   property p_bottom;
      o_bottom == (o_count_value == 16'h0000);
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom flag wrong");
   property p_max;
      o_max == (o_count_value == 16'hffff);
   endproperty
   a_max: assert property (p_max) else $error("max flag wrong");
   property p_lo_write;
      wr_lo |=> o_count_value[7:0] == $past(i_wdata);
   endproperty
   a_lo_write: assert property (p_lo_write) else $error("low write lost");
   property p_pair;
      wr_hi ##1 wr_lo |=> o_count_value == {$past(i_wdata, 2), $past(i_wdata)};
   endproperty
   a_pair: assert property (p_pair) else $error("16-bit write wrong");
   property p_lo_read;
      rd_lo |=> o_rdata == $past(o_count_value[7:0]);
   endproperty
   a_lo_read: assert property (p_lo_read) else $error("low read wrong");
   property p_hi_read;
      rd_lo ##1 rd_hi |=> o_rdata == $past(o_count_value[15:8], 2);
   endproperty
   a_hi_read: assert property (p_hi_read) else $error("high read not latched");
   // without a write the count only holds, steps by one or clears
   property p_step;
      !wr_lo |=> (o_count_value - $past(o_count_value)) inside {16'h0000, 16'h0001, 16'hffff}
         || o_count_value == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("count jumped");
   property p_flag_hold;
      o_overflow_flag && !i_overflow_clear |=> o_overflow_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");
   property p_flag_cause;
      $rose(o_overflow_flag) |-> (o_max || o_top || o_bottom) || $past(o_max || o_top || o_bottom);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("flag without cause");
endmodule : tmr16_core_chk
bind tmr16_core tmr16_core_chk u_chk (.i_clk_sys, .i_reset_n, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
   .i_overflow_clear, .o_overflow_flag, .o_bottom, .o_top, .o_max, .o_count_value);
`default_nettype wire

// >>> verif/tmr16_cpu_model.sv
// behavioural 8-bit processor on the timer byte bus
`timescale 1ns/10ps
`default_nettype none
module tmr16_cpu_model (
   input wire logic i_clk_sys,
   output logic [3:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata
);
   initial begin
      o_addr = 4'hf;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   // single byte write; the released bus shows the inverted byte
   task automatic wr8(input logic [3:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk_sys);
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask : wr8
   task automatic rd8(input logic [3:0] a, output logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk_sys);
      o_rd = 1'b0;
      d = i_rdata;
   endtask : rd8
   // high byte then low byte, back to back, never interrupted
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      @(negedge i_clk_sys);
      o_addr = lo + 4'h1;
      o_wdata = v[15:8];
      o_wr = 1'b1;
      @(negedge i_clk_sys);
      o_addr = lo;
      o_wdata = v[7:0];
      @(negedge i_clk_sys);
      o_wr = 1'b0;
      o_wdata = ~v[7:0];
   endtask : wr16
   // low byte first so a count or capture high byte comes from the latch
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      @(negedge i_clk_sys);
      o_addr = lo;
      o_rd = 1'b1;
      @(negedge i_clk_sys);
      o_addr = lo + 4'h1;
      v[7:0] = i_rdata;
      @(negedge i_clk_sys);
      o_rd = 1'b0;
      v[15:8] = i_rdata;
   endtask : rd16
endmodule : tmr16_cpu_model
`default_nettype wire

// >>> verif/tmr16_core_tb.sv
// self-checking testbench for the 16-bit timer/counter core
`timescale 1ns/10ps
`default_nettype none
module tmr16_core_tb;
   localparam logic [3:0] CL = tmr16_pkg::ADDR_COUNT_LO;
   localparam logic [3:0] AL = tmr16_pkg::ADDR_CMP_A_LO;
   localparam logic [3:0] BL = tmr16_pkg::ADDR_CMP_B_LO;
   localparam logic [3:0] PL = tmr16_pkg::ADDR_CAPT_LO;
   logic clk = 1'b0; // system clock
   logic reset_n = 1'b0; // reset, active low
   logic [3:0] addr;
   logic wr;
   logic rd;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ext_pin = 1'b0; // external tick pin
   logic cap = 1'b0; // capture strobe
   logic ovf_clr = 1'b0; // overflow clear
   logic ovf;
   logic bottom;
   logic top;
   logic max_hit;
   logic [15:0] count;
   logic [15:0] got;
   logic [15:0] v;
   logic [7:0] b;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   int seed = 32'hb5cc;
   always #10 clk = ~clk;
   tmr16_cpu_model u_cpu (.i_clk_sys(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata), .i_rdata(rdata));
   tmr16_core u_dut (.i_clk_sys(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wdata), .o_rdata(rdata), .i_ext_pin(ext_pin), .i_capture(cap), .i_overflow_clear(ovf_clr),
      .o_overflow_flag(ovf), .o_bottom(bottom), .o_top(top), .o_max(max_hit), .o_count_value(count));
   // top of the fixed-resolution modes
   function automatic logic [15:0] top_of(input logic [1:0] m);
      case (m)
         2'h1: return tmr16_pkg::TOP_8BIT;
         2'h2: return tmr16_pkg::TOP_9BIT;
         default: return tmr16_pkg::TOP_10BIT;
      endcase
   endfunction : top_of
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic chk1(input logic s, input logic e);
      check({15'h0000, s}, {15'h0000, e});
   endtask : chk1
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // mode field split over both control bytes
   task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
      u_cpu.wr8(tmr16_pkg::ADDR_CTRL_A, {6'h00, m[1:0]});
      u_cpu.wr8(tmr16_pkg::ADDR_CTRL_B, {3'h0, m[3:2], cs});
   endtask : set_mode
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      check(count, 16'h0000);
      chk1(bottom, 1'b1);
      chk1(ovf, 1'b0);
      reset_n = 1'b1;
      $display("test reset done");
      u_cpu.wr16(CL, 16'h01ff);
      check(count, 16'h01ff);
      for (int n = 0; n < 8; n++) begin
         v = 16'($random(seed));
         u_cpu.wr16(CL, v);
         u_cpu.rd16(CL, got);
         check(got, v);
      end
      $display("test count access done");
      u_cpu.wr16(AL, 16'h5678);
      u_cpu.wr16(CL, 16'h1234);
      u_cpu.rd8(CL, b);
      check({8'h00, b}, 16'h0034);
      u_cpu.rd8(AL + 4'h1, b);
      check({8'h00, b}, 16'h0056);
      u_cpu.rd8(CL + 4'h1, b);
      check({8'h00, b}, 16'h0012);
      u_cpu.wr8(CL + 4'h1, 8'h9a);
      u_cpu.wr8(CL, 8'h01);
      u_cpu.wr8(BL, 8'h02);
      check(count, 16'h9a01);
      u_cpu.rd16(BL, got);
      check(got, 16'h9a02);
      $display("test shared latch done");
      u_cpu.wr16(PL, 16'habcd);
      u_cpu.rd16(PL, got);
      check(got, 16'h0000);
      cap = 1'b1;
      @(negedge clk);
      cap = 1'b0;
      u_cpu.rd16(PL, got);
      check(got, 16'h9a01);
      set_mode(4'hc, tmr16_pkg::CS_STOPPED);
      u_cpu.wr16(PL, 16'habcd);
      u_cpu.rd16(PL, got);
      check(got, 16'habcd);
      u_cpu.wr16(CL, 16'habcd);
      chk1(top, 1'b1);
      for (int m = 1; m < 4; m++) begin
         set_mode(4'(m), tmr16_pkg::CS_STOPPED);
         u_cpu.wr16(CL, top_of(2'(m)));
         chk1(top, 1'b1);
         u_cpu.wr16(CL, top_of(2'(m)) - 16'h0001);
         chk1(top, 1'b0);
      end
      $display("test top select done");
      u_cpu.wr16(CL, 16'h00f0);
      set_mode(4'h1, tmr16_pkg::CS_DIV1);
      for (int k = 0; k < 100 && top !== 1'b1; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      check(count, 16'h00fd);
      for (int k = 0; k < 300 && bottom !== 1'b1; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk1(ovf, 1'b1);
      ovf_clr = 1'b1;
      @(negedge clk);
      ovf_clr = 1'b0;
      @(negedge clk);
      chk1(ovf, 1'b0);
      set_mode(4'h0, tmr16_pkg::CS_DIV1);
      u_cpu.wr16(CL, 16'hfff0);
      check(count, 16'hfff0);
      for (int k = 0; k < 40 && max_hit !== 1'b1; k++) @(negedge clk);
      chk1(max_hit, 1'b1);
      repeat (2) @(negedge clk);
      chk1(ovf, 1'b1);
      $display("test running count done");
      set_mode(4'h0, tmr16_pkg::CS_STOPPED);
      u_cpu.wr16(CL, 16'h0042);
      repeat (20) @(negedge clk);
      check(count, 16'h0042);
      set_mode(4'h0, tmr16_pkg::CS_EXT_RISE);
      repeat (3) begin
         repeat (8) @(negedge clk);
         ext_pin = 1'b1;
         repeat (8) @(negedge clk);
         ext_pin = 1'b0;
      end
      repeat (8) @(negedge clk);
      check(count, 16'h0045);
      set_mode(4'h0, tmr16_pkg::CS_EXT_FALL);
      repeat (2) begin
         ext_pin = 1'b1;
         repeat (8) @(negedge clk);
         ext_pin = 1'b0;
         repeat (8) @(negedge clk);
      end
      check(count, 16'h0047);
      set_mode(4'h0, tmr16_pkg::CS_DIV8);
      v = count;
      repeat (64) @(negedge clk);
      check(count - v, 16'h0008);
      $display("test tick source done");
      ovf_clr = 1'b1;
      set_mode(4'h5, tmr16_pkg::CS_STOPPED);
      ovf_clr = 1'b0;
      u_cpu.wr16(CL, 16'h00fc);
      set_mode(4'h5, tmr16_pkg::CS_DIV1);
      for (int k = 0; k < 20 && top !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      check(count, 16'h0000);
      chk1(ovf, 1'b1);
      ovf_clr = 1'b1;
      set_mode(4'h4, tmr16_pkg::CS_STOPPED);
      ovf_clr = 1'b0;
      u_cpu.wr16(AL, 16'h0010);
      u_cpu.wr16(CL, 16'h0000);
      set_mode(4'h4, tmr16_pkg::CS_DIV1);
      for (int k = 0; k < 40 && top !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      check(count, 16'h0000);
      chk1(ovf, 1'b0);
      set_mode(4'hf, tmr16_pkg::CS_STOPPED);
      u_cpu.wr16(AL, 16'h0020);
      u_cpu.wr16(CL, 16'h0010);
      chk1(top, 1'b1);
      set_mode(4'hf, tmr16_pkg::CS_DIV1);
      @(negedge clk);
      chk1(ovf, 1'b1);
      for (int k = 0; k < 40 && top !== 1'b1; k++) @(negedge clk);
      check(count, 16'h0020);
      u_cpu.wr8(CL + 4'h1, 8'h5a);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      repeat (20) @(negedge clk);
      check(count, 16'h0000);
      chk1(ovf, 1'b0);
      u_cpu.rd8(CL + 4'h1, b);
      check({8'h00, b}, 16'h0000);
      $display("test modes and reset done");
      tally_and_finish();
   end
endmodule : tmr16_core_tb
`default_nettype wire
